// ### inc/sfwp_pkg.sv
// package for the spi fram write protect and hold block
// Overview of operation
// [R1] region field 00 protects nothing, 11 protects 000h to 7FFh
// [R2] region field 01 protects upper quarter, 600h to 7FFh
// [R3] region field 10 protects upper half, 400h to 7FFh
// [R4] latch clear: no memory write and no status write at all
// [R5] latch set: write unprotected bytes, never protected ones
// [R6] latch set: status write blocked only if lock bit 1 and wp pin low
// [R7] hold low while select low pauses the command without aborting
// [R8] hold start and end are timed by serial clock level at hold change
// [R9] host raises hold with clock low if it dropped hold with clock low
// [R10] host raises hold with clock high if it dropped hold with clock high
// [R11] in hold, command stalls and serial clock and data are ignored
// [R12] in hold during status or memory read, data output floats
// [R13] select rising during hold aborts the command
// [R14] abort before opcode known leaves the latch as it was
// [R15] opcode 06h sets the latch, 04h clears it; host sets it first
// [R16] status write never changes the latch; that data bit is ignored
// [R17] write opcode 02h takes 16-bit address, upper 5 bits dropped
// [R18] burst writes check each byte address against the region
// [R19] hold input ignored while select is high
package sfwp_pkg;
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLR_WEL = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_RD_MEM = 8'h03;
    localparam logic [7:0] OP_WR_MEM = 8'h02;
    localparam logic [7:0] OP_RD_ID = 8'h9f;
    localparam int ADDR_W = 11;
    localparam int DEPTH = 2048;
    localparam logic [10:0] QUARTER_BASE = 11'h600;
    localparam logic [10:0] HALF_BASE = 11'h400;
    localparam logic [10:0] TOP_ADDR = 11'h7ff;
    localparam int STAT_LOCK_BIT = 7;
    localparam int STAT_RSEL_HI = 3;
    localparam int STAT_RSEL_LO = 2;
    localparam int STAT_WEL_BIT = 1;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_WR_MASK = 8'h8c;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [4:0] ADDR_BITS_RESET = 5'h00;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h0f;
    // arbitrary neutral identification bytes
    localparam logic [31:0] DEVICE_ID = 32'h5a_00_12_34;
    typedef enum logic [2:0] {
        SFWP_OPC, SFWP_ADDR, SFWP_WDATA, SFWP_SDATA, SFWP_RDATA, SFWP_RSTAT,
        SFWP_RID, SFWP_IDLE
    } sfwp_state_t;
endpackage

// ### core/sfwp_mem.sv
// byte-wide array with registered read data
`timescale 1ns/1ps
module sfwp_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [10:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [10:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:sfwp_pkg::DEPTH-1];

    // write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ### core/sfwp_top.sv
// spi fram core with block protect, write protect and hold
`timescale 1ns/1ps
module sfwp_top (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic WP_N,
    input wire logic HOLD_N,
    output logic SO_O,
    output logic SO_OE,
    output logic WRITE_ENABLE_LATCH,
    output logic REGION_SELECT_HI,
    output logic REGION_SELECT_LO,
    output logic STATUS_LOCK_ENABLE,
    output logic MEM_WRITE_DROP
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] cs_s, sck_s, si_s, wp_s, hold_s;
    logic sck_prev_q;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cs_s <= 2'h3;
            sck_s <= 2'h0;
            si_s <= 2'h0;
            wp_s <= 2'h3;
            hold_s <= 2'h3;
        end else begin
            cs_s <= {cs_s[0], CS_N};
            sck_s <= {sck_s[0], SCK};
            si_s <= {si_s[0], SI};
            wp_s <= {wp_s[0], WP_N};
            hold_s <= {hold_s[0], HOLD_N};
        end
    end

    logic cs_n, sck, si, wp_n, hold_n;
    assign cs_n = cs_s[1];
    assign sck = sck_s[1];
    assign si = si_s[1];
    assign wp_n = wp_s[1];
    assign hold_n = hold_s[1];

    ////////////////////////////////////////////////////////////////////////
    // hold tracking
    logic held_q, hold_sck_q;
    logic hold_go, hold_end;
    // enter when hold low with select low; leave on same clock level
    assign hold_go = !cs_n && !hold_n && !held_q; // see [R7] see [R19]
    assign hold_end = held_q && hold_n && (sck == hold_sck_q); // see [R8]

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            held_q <= 1'b0;
            hold_sck_q <= 1'b0;
        end else if (cs_n) begin
            held_q <= 1'b0; // see [R19]
        end else if (hold_go) begin
            held_q <= 1'b1;
            hold_sck_q <= sck; // see [R8] see [R9] see [R10]
        end else if (hold_end) begin
            held_q <= 1'b0;
        end
    end

    // clock edges only count outside hold; sck ignored while held
    logic active, rise, fall;
    assign active = !cs_n && !held_q && !hold_go; // see [R11]
    assign rise = active && sck && !sck_prev_q;
    assign fall = active && !sck && sck_prev_q;

    // previous clock level, tracked through hold so no false edge appears
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection decode
    function automatic logic in_region(input logic [1:0] rsel,
                                       input logic [10:0] a);
        case (rsel)
            2'h0: in_region = 1'b0; // see [R1]
            2'h1: in_region = a >= sfwp_pkg::QUARTER_BASE; // see [R2]
            2'h2: in_region = a >= sfwp_pkg::HALF_BASE; // see [R3]
            default: in_region = a <= sfwp_pkg::TOP_ADDR; // see [R1]
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // command engine
    sfwp_pkg::sfwp_state_t state_q;
    logic [7:0] shift_q, stat_q, rbyte_q;
    logic [2:0] bit_q;
    logic [4:0] abit_q;
    logic [10:0] addr_q;
    logic wel_q, mem_we, opc_wr_q;
    logic [7:0] mem_rd;
    logic [7:0] byte_in;
    logic [4:0] id_bit_q;
    logic [1:0] rsel;
    assign rsel = {stat_q[sfwp_pkg::STAT_RSEL_HI],
                   stat_q[sfwp_pkg::STAT_RSEL_LO]};
    assign byte_in = {shift_q[6:0], si};
    // write only when latch set and byte outside the region
    assign mem_we = rise && (state_q == sfwp_pkg::SFWP_WDATA) &&
                    (bit_q == 3'h7) && wel_q &&
                    !in_region(rsel, addr_q); // see [R4] see [R5] see [R18]

    sfwp_mem u_mem (
        .clk(CLK),
        .we(mem_we),
        .waddr(addr_q),
        .wdata(byte_in),
        .raddr(addr_q),
        .rdata(mem_rd)
    );

    // sequencing; select high aborts, wel untouched unless opcode done
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= sfwp_pkg::SFWP_IDLE;
            shift_q <= 8'h00;
            bit_q <= sfwp_pkg::BIT_CNT_RESET;
            abit_q <= sfwp_pkg::ADDR_BITS_RESET;
            addr_q <= 11'h000;
            id_bit_q <= 5'h00;
        end else if (cs_n) begin
            state_q <= sfwp_pkg::SFWP_IDLE; // see [R13] see [R14]
            bit_q <= sfwp_pkg::BIT_CNT_RESET;
        end else if (state_q == sfwp_pkg::SFWP_IDLE) begin
            state_q <= sfwp_pkg::SFWP_OPC;
        end else if (rise) begin
            shift_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            case (state_q)
                sfwp_pkg::SFWP_OPC: begin
                    if (bit_q == 3'h7) begin
                        abit_q <= sfwp_pkg::ADDR_BITS_RESET;
                        id_bit_q <= 5'h00;
                        case (byte_in)
                            sfwp_pkg::OP_WR_MEM,
                            sfwp_pkg::OP_RD_MEM:
                                state_q <= sfwp_pkg::SFWP_ADDR;
                            sfwp_pkg::OP_WR_STAT:
                                state_q <= sfwp_pkg::SFWP_SDATA;
                            sfwp_pkg::OP_RD_STAT:
                                state_q <= sfwp_pkg::SFWP_RSTAT;
                            sfwp_pkg::OP_RD_ID:
                                state_q <= sfwp_pkg::SFWP_RID;
                            default: state_q <= sfwp_pkg::SFWP_RID;
                        endcase
                    end
                end
                sfwp_pkg::SFWP_ADDR: begin
                    // upper 5 address bits fall off the 11-bit shift
                    addr_q <= {addr_q[9:0], si}; // see [R17]
                    abit_q <= abit_q + 5'h01;
                    if (abit_q == sfwp_pkg::ADDR_LAST_BIT) begin
                        state_q <= opc_wr_q ? sfwp_pkg::SFWP_WDATA :
                                              sfwp_pkg::SFWP_RDATA;
                    end
                end
                sfwp_pkg::SFWP_WDATA,
                sfwp_pkg::SFWP_RDATA: begin
                    if (bit_q == 3'h7) begin
                        addr_q <= addr_q + 11'h001; // see [R18]
                    end
                end
                sfwp_pkg::SFWP_RID: begin
                    if (id_bit_q != 5'h1f) begin
                        id_bit_q <= id_bit_q + 5'h01;
                    end
                end
                default: ;
            endcase
        end
    end

    // remember whether the addressed command writes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            opc_wr_q <= 1'b0;
        end else if (rise && state_q == sfwp_pkg::SFWP_OPC &&
                     bit_q == 3'h7) begin
            opc_wr_q <= byte_in == sfwp_pkg::OP_WR_MEM;
        end
    end

    // write enable latch, only changed by completed opcodes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wel_q <= 1'b0;
        end else if (rise && state_q == sfwp_pkg::SFWP_OPC &&
                     bit_q == 3'h7) begin
            if (byte_in == sfwp_pkg::OP_SET_WEL) begin
                wel_q <= 1'b1; // see [R15]
            end else if (byte_in == sfwp_pkg::OP_CLR_WEL) begin
                wel_q <= 1'b0; // see [R15]
            end
        end
    end

    // status register; lock bit with wp low blocks the write
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            stat_q <= sfwp_pkg::STAT_RESET;
        end else if (rise && state_q == sfwp_pkg::SFWP_SDATA &&
                     bit_q == 3'h7 && wel_q && // see [R4]
                     !(stat_q[sfwp_pkg::STAT_LOCK_BIT] && !wp_n)) begin
            stat_q <= byte_in & sfwp_pkg::STAT_WR_MASK; // see [R6] see [R16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output on falling clock, floats in hold
    logic [7:0] stat_view;
    assign stat_view = stat_q | ({7'h00, wel_q} << sfwp_pkg::STAT_WEL_BIT);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SO_O <= 1'b0;
            SO_OE <= 1'b0;
            rbyte_q <= 8'h00;
        end else if (cs_n || held_q || hold_go) begin
            SO_OE <= 1'b0; // see [R12]
        end else if (fall) begin
            case (state_q)
                sfwp_pkg::SFWP_RSTAT: begin
                    SO_OE <= 1'b1;
                    SO_O <= stat_view[3'h7 - bit_q];
                end
                sfwp_pkg::SFWP_RDATA: begin
                    SO_OE <= 1'b1;
                    if (bit_q == 3'h0) begin
                        rbyte_q <= {mem_rd[6:0], 1'b0};
                        SO_O <= mem_rd[7];
                    end else begin
                        rbyte_q <= {rbyte_q[6:0], 1'b0};
                        SO_O <= rbyte_q[7];
                    end
                end
                sfwp_pkg::SFWP_RID: begin
                    SO_OE <= 1'b1;
                    SO_O <= sfwp_pkg::DEVICE_ID[5'h1f - id_bit_q];
                end
                default: SO_OE <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pins
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            WRITE_ENABLE_LATCH <= 1'b0;
            REGION_SELECT_HI <= 1'b0;
            REGION_SELECT_LO <= 1'b0;
            STATUS_LOCK_ENABLE <= 1'b0;
            MEM_WRITE_DROP <= 1'b0;
        end else begin
            WRITE_ENABLE_LATCH <= wel_q;
            REGION_SELECT_HI <= rsel[1];
            REGION_SELECT_LO <= rsel[0];
            STATUS_LOCK_ENABLE <= stat_q[sfwp_pkg::STAT_LOCK_BIT];
            MEM_WRITE_DROP <= rise && state_q == sfwp_pkg::SFWP_WDATA &&
                              bit_q == 3'h7 && !mem_we; // see [R18]
        end
    end
endmodule

// ### bench/sfwp_monitor.sv
// checker for the write protect and hold block
`timescale 1ns/1ps
module sfwp_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic WP_N,
    input wire logic HOLD_N,
    input wire logic SO_OE,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic REGION_SELECT_HI,
    input wire logic REGION_SELECT_LO,
    input wire logic STATUS_LOCK_ENABLE,
    input wire logic MEM_WRITE_DROP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    // output enable against select and hold
    oe_idle_a: assert property (CS_N [*4] |-> !SO_OE)
        else $error("data output driven between commands");
    oe_hold_a: assert property (
        (!HOLD_N && !CS_N) [*5] |-> !SO_OE)
        else $error("data output driven during hold");
    ////////////////////////////////////////////////////////////////////////
    // status bits only move when allowed
    region_wel_a: assert property (
        !WRITE_ENABLE_LATCH && !$past(WRITE_ENABLE_LATCH) |->
        $stable({REGION_SELECT_HI, REGION_SELECT_LO, STATUS_LOCK_ENABLE}))
        else $error("status changed with latch clear");
    lock_wp_a: assert property (
        (STATUS_LOCK_ENABLE && !WP_N) [*6] |-> $stable(REGION_SELECT_HI)
        && $stable(REGION_SELECT_LO) && STATUS_LOCK_ENABLE)
        else $error("status changed while locked");
    wel_idle_a: assert property (
        CS_N [*8] |-> $stable(WRITE_ENABLE_LATCH))
        else $error("latch changed outside a command");
    hold_freeze_a: assert property (
        (!HOLD_N && !CS_N) [*8] |-> $stable(WRITE_ENABLE_LATCH)
        && !MEM_WRITE_DROP)
        else $error("command progressed during hold");
    ////////////////////////////////////////////////////////////////////////
    // refused bytes
    drop_pulse_a: assert property (
        MEM_WRITE_DROP |=> (!MEM_WRITE_DROP) [*8])
        else $error("drop pulse too long or too close");
    drop_frame_a: assert property (
        MEM_WRITE_DROP |-> !$past(CS_N, 4))
        else $error("drop outside a command");
endmodule

// ### bench/sfwp_host.sv
// spi host model driving select, clock, data and hold
`timescale 1ns/1ps
module sfwp_host (
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so
);
    // idle pins, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // send the top n bits, msb first, mode 0
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = 31; i > 31 - n; i--) begin
            si = v[i];
            #400 sck = 1'b1;
            #400 sck = 1'b0;
        end
    endtask
    // select edge; released data line toggles
    task automatic sel(input logic lvl);
        #400 cs_n = lvl;
        if (lvl) si = ~si;
    endtask
    // hold entered with clock low, clock and data wiggled meanwhile
    task automatic hold_on(input int n);
        hold_n = 1'b0;
        repeat (n) begin
            si = ~si;
            #400 sck = 1'b1;
            #400 sck = 1'b0;
        end
        #400;
    endtask
    // hold left with clock low again
    task automatic hold_off();
        hold_n = 1'b1;
        #400;
    endtask
    // one bit clocked in, then hold taken and left with the clock high
    task automatic hold_high(input logic b, input int n);
        si = b;
        #400 sck = 1'b1;
        #400 hold_n = 1'b0;
        repeat (n) begin
            si = ~si;
            #400 sck = 1'b0;
            #400 sck = 1'b1;
        end
        #400 hold_n = 1'b1;
        #400 sck = 1'b0;
    endtask
    // read one byte, sampled on the rising clock, msb first
    task automatic rd(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            #400 sck = 1'b1;
            v[i] = so;
            #400 sck = 1'b0;
        end
    endtask
endmodule

// ### bench/sfwp_test.sv
// bench for the write protect and hold block
`timescale 1ns/1ps
module sfwp_test;
    logic clk, rstn, wp_n, cs_n, sck, si, hold_n;
    logic so_o, so_oe, write_enable_latch, rhi, rlo, lock, drop;
    int n_errors = 0;
    int n_tests = 0;
    int n_drop = 0;
    int cyc = 0;
    int base;
    logic [7:0] rv;
    // row: latch, region field, address, drop expected
    localparam logic [14:0] ROWS [7] = '{
        {1'b1, 2'h0, 11'h7ff, 1'b0}, {1'b1, 2'h3, 11'h000, 1'b1},
        {1'b1, 2'h1, 11'h5ff, 1'b0}, {1'b1, 2'h1, 11'h600, 1'b1},
        {1'b1, 2'h2, 11'h3ff, 1'b0}, {1'b1, 2'h2, 11'h400, 1'b1},
        {1'b0, 2'h0, 11'h123, 1'b1}};
    ////////////////////////////////////////////////////////////////////////
    // clock, drop counting and timeout
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (drop === 1'b1) n_drop++;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end
    sfwp_top u_sfwp_top (.CLK(clk), .RSTN(rstn), .CS_N(cs_n), .SCK(sck),
        .SI(si), .WP_N(wp_n), .HOLD_N(hold_n), .SO_O(so_o), .SO_OE(so_oe),
        .WRITE_ENABLE_LATCH(write_enable_latch), .REGION_SELECT_HI(rhi),
        .REGION_SELECT_LO(rlo), .STATUS_LOCK_ENABLE(lock),
        .MEM_WRITE_DROP(drop));
    sfwp_host u_sfwp_host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so(so_o));
    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] arg,
            input int n);
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits({op, arg}, n);
        u_sfwp_host.sel(1'b1);
        settle();
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("reset", 8'h00, {2'h0, so_oe, write_enable_latch, rhi, rlo, lock, drop});
        rstn = 1'b1;
        settle();
        $display("done reset");
    endtask
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        wp_n = 1'b1;
        do_reset();
        foreach (ROWS[i]) begin
            cmd(sfwp_pkg::OP_SET_WEL, 24'h0, 8);
            cmd(sfwp_pkg::OP_WR_STAT, {4'h0, ROWS[i][13:12], 18'h0}, 16);
            chk("region", {6'h0, ROWS[i][13:12]},
                {6'h0, rhi, rlo});
            chk("latch kept", 8'h01, {7'h0, write_enable_latch});
            if (!ROWS[i][14]) cmd(sfwp_pkg::OP_CLR_WEL, 24'h0, 8);
            base = n_drop;
            cmd(sfwp_pkg::OP_WR_MEM, {5'h15, ROWS[i][11:1], 8'h3c}, 32);
            chk("drop", {7'h0, ROWS[i][0]},
                8'(n_drop - base));
        end
        $display("done table");
        cmd(sfwp_pkg::OP_SET_WEL, 24'h0, 8);
        cmd(sfwp_pkg::OP_WR_STAT, 24'h8c0000, 16);
        chk("lock set", 8'h07, {5'h0, lock, rhi, rlo});
        @(posedge clk);
        #1 wp_n = 1'b0;
        cmd(sfwp_pkg::OP_SET_WEL, 24'h0, 8);
        cmd(sfwp_pkg::OP_WR_STAT, 24'h0, 16);
        chk("locked", 8'h07, {5'h0, lock, rhi, rlo});
        @(posedge clk);
        #1 wp_n = 1'b1;
        cmd(sfwp_pkg::OP_SET_WEL, 24'h0, 8);
        cmd(sfwp_pkg::OP_WR_STAT, 24'h040000, 16);
        chk("unlocked", 8'h01, {5'h0, lock, rhi, rlo});
        cmd(sfwp_pkg::OP_CLR_WEL, 24'h0, 8);
        cmd(sfwp_pkg::OP_WR_STAT, 24'h8c0000, 16);
        chk("latch clear", 8'h01, {5'h0, lock, rhi, rlo});
        $display("done status");
        cmd(sfwp_pkg::OP_SET_WEL, 24'h0, 8);
        base = n_drop;
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits({sfwp_pkg::OP_WR_MEM, 16'h05ff, 8'ha5}, 32);
        u_sfwp_host.bits(32'h5a000000, 8);
        u_sfwp_host.sel(1'b1);
        settle();
        chk("burst drops", 8'h01, 8'(n_drop - base));
        // read back, junk in the ignored upper address bits
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits({sfwp_pkg::OP_RD_MEM, 16'hfdff, 8'h0}, 24);
        u_sfwp_host.rd(rv);
        u_sfwp_host.sel(1'b1);
        settle();
        chk("read back", 8'ha5, rv);
        // first identification byte
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits({sfwp_pkg::OP_RD_ID, 24'h0}, 8);
        u_sfwp_host.rd(rv);
        u_sfwp_host.sel(1'b1);
        settle();
        chk("id byte", sfwp_pkg::DEVICE_ID[31:24], rv);
        $display("done burst");
        cmd(sfwp_pkg::OP_CLR_WEL, 24'h0, 8);
        chk("latch cleared", 8'h00, {7'h0, write_enable_latch});
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits(32'h0, 4);
        u_sfwp_host.hold_on(3);
        u_sfwp_host.hold_off();
        u_sfwp_host.bits(32'h60000000, 4);
        u_sfwp_host.sel(1'b1);
        settle();
        chk("hold resume", 8'h01, {7'h0, write_enable_latch});
        // hold taken and left with the clock high
        cmd(sfwp_pkg::OP_CLR_WEL, 24'h0, 8);
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits(32'h0, 4);
        u_sfwp_host.hold_high(1'b0, 3);
        u_sfwp_host.bits(32'hc0000000, 3);
        u_sfwp_host.sel(1'b1);
        settle();
        chk("hold clock high", 8'h01, {7'h0, write_enable_latch});
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits(32'h04000000, 7);
        u_sfwp_host.hold_on(2);
        u_sfwp_host.sel(1'b1);
        u_sfwp_host.hold_off();
        settle();
        chk("hold abort", 8'h01, {7'h0, write_enable_latch});
        u_sfwp_host.sel(1'b0);
        u_sfwp_host.bits({sfwp_pkg::OP_RD_STAT, 24'h0}, 8);
        u_sfwp_host.rd(rv);
        chk("status read", 8'h06, rv);
        settle();
        chk("read drives", 8'h01, {7'h0, so_oe});
        u_sfwp_host.hold_on(0);
        settle();
        chk("hold floats", 8'h00, {7'h0, so_oe});
        u_sfwp_host.hold_off();
        u_sfwp_host.sel(1'b1);
        settle();
        $display("done hold");
        do_reset();
        print_verdict();
    end
endmodule
bind sfwp_top sfwp_monitor u_sfwp_monitor (.CLK(CLK), .RSTN(RSTN),
    .CS_N(CS_N), .WP_N(WP_N), .HOLD_N(HOLD_N), .SO_OE(SO_OE),
    .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
    .REGION_SELECT_HI(REGION_SELECT_HI), .REGION_SELECT_LO(REGION_SELECT_LO),
    .STATUS_LOCK_ENABLE(STATUS_LOCK_ENABLE), .MEM_WRITE_DROP(MEM_WRITE_DROP));
